// [sso_status_outputs.sv]
// servo drive status and feedback output logic
`timescale 1ns/1ps
module sso_status_outputs #(
	parameter int POWERUP_CYC    = sso_pkg::POWERUP_CYC,
	parameter int BRAKE_UNIT_CYC = sso_pkg::BRAKE_UNIT_CYC
) (
	// clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              rst,
	// command pulses
	input  wire logic                              cmd_pin_a,
	input  wire logic                              cmd_pin_b,
	input  wire logic [sso_pkg::MODE_W-1:0]        cmd_mode,
	input  wire logic                              cmd_neg_logic,
	input  wire logic                              deviation_clear,
	// encoder and direction
	input  wire logic                              enc_a_in,
	input  wire logic                              enc_b_in,
	input  wire logic                              enc_z_in,
	input  wire logic                              dir_reverse_n,
	input  wire logic                              dir_reverse_cfg,
	// settings
	input  wire logic [sso_pkg::WIN_W-1:0]         in_position_window,
	input  wire logic [sso_pkg::SETUP_W-1:0]       setup_word_one,
	input  wire logic [sso_pkg::SPD_W-1:0]         rotation_detect_threshold,
	input  wire logic [sso_pkg::SPD_W-1:0]         fwd_external_current_limit,
	input  wire logic [sso_pkg::SPD_W-1:0]         rev_external_current_limit,
	input  wire logic [sso_pkg::SPD_W-1:0]         fwd_torque_limit,
	input  wire logic [sso_pkg::SPD_W-1:0]         rev_torque_limit,
	input  wire logic [sso_pkg::DIV_W-1:0]         encoder_divider_rate,
	input  wire logic [sso_pkg::BRK_W-1:0]         brake_timing_a,
	input  wire logic [sso_pkg::BRK_W-1:0]         brake_timing_b,
	input  wire logic [sso_pkg::BRK_W-1:0]         brake_timing_c,
	// drive measurements and control
	input  wire logic signed [sso_pkg::SPD_W-1:0]  motor_speed,
	input  wire logic signed [sso_pkg::SPD_W-1:0]  motor_torque,
	input  wire logic                              fwd_ext_limit_in,
	input  wire logic                              rev_ext_limit_in,
	input  wire logic                              fault_valid,
	input  wire logic [sso_pkg::CODE_W-1:0]        fault_code,
	input  wire logic                              alarm_reset,
	input  wire logic                              servo_on,
	// status outputs
	output logic                                   in_position_out,
	output logic                                   detect_out,
	output logic                                   alarm_out,
	output logic                                   alarm_code_bit0,
	output logic                                   alarm_code_bit1,
	output logic                                   alarm_code_bit2,
	output logic                                   brake_interlock_out,
	// regenerated encoder and motor command
	output logic                                   enc_a_out,
	output logic                                   enc_b_out,
	output logic                                   enc_z_out,
	output logic                                   motor_step_out,
	output logic                                   motor_fwd_out
);
	import sso_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [SPD_W-1:0] mag(input logic signed [SPD_W-1:0] v);
		mag = v[SPD_W-1] ? SPD_W'(-v) : SPD_W'(v);
	endfunction : mag

	function automatic logic [SPD_W-1:0] lesser(input logic [SPD_W-1:0] x,
		input logic [SPD_W-1:0] y);
		lesser = (x < y) ? x : y;
	endfunction : lesser

	sso_step_if cmd_if ();
	sso_step_if fb_if ();

	logic                 reversed, cmd_fast;
	logic                 enc_a_r, enc_a_nxt, enc_b_r, enc_b_nxt;
	logic                 fb_step_r, fb_step_nxt, fb_fwd_r, fb_fwd_nxt;
	logic                 mstep_r, mstep_nxt, mfwd_r, mfwd_nxt;
	logic [DEV_W-1:0]     dev_r, dev_nxt, dev_mag;
	logic                 inpos_r, inpos_nxt, det_r, det_nxt;
	logic [SPD_W-1:0]     trq_lim;
	logic                 err_any;
	logic [CODE_W-1:0]    err_code;
	sso_alm_state_t       alm_r, alm_nxt;
	logic [CNT_W-1:0]     pwr_r, pwr_nxt;
	logic                 pwr_done_r, pwr_done_nxt;
	logic                 alm_out_r, alm_out_nxt;
	logic [CODE_W-1:0]    code_r, code_nxt;
	sso_brk_state_t       brk_r, brk_nxt;
	logic [CNT_W-1:0]     tick_r, tick_nxt;
	logic [BRK_W-1:0]     units_r, units_nxt;
	logic                 brk_out_r, brk_out_nxt;
	logic                 unit_tick, run_req, stopped;

	// ----------------------------------------
	// command pulses and direction
	// ----------------------------------------
	sso_cmd_pulse u_cmd (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.pin_a     (cmd_pin_a),
		.pin_b     (cmd_pin_b),
		.mode      (cmd_mode),
		.neg_logic (cmd_neg_logic),
		.step_o    (cmd_if.src),
		.too_fast  (cmd_fast)
	);

	assign reversed = ~dir_reverse_n | dir_reverse_cfg;

	// ----------------------------------------
	// encoder feedback decode
	// ----------------------------------------
	always_comb begin
		enc_a_nxt   = enc_a_in;
		enc_b_nxt   = enc_b_in;
		fb_step_nxt = (enc_a_in ^ enc_a_r) | (enc_b_in ^ enc_b_r);
		fb_fwd_nxt  = (enc_a_in ^ enc_a_r) ? (enc_a_in ^ enc_b_in) : ~(enc_a_in ^ enc_b_in);
		// a positive command turns the motor the other way when reversed
		mstep_nxt   = cmd_if.step;
		mfwd_nxt    = cmd_if.step ? (cmd_if.fwd ^ reversed) : mfwd_r;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			enc_a_r   <= 1'b0;
			enc_b_r   <= 1'b0;
			fb_step_r <= 1'b0;
			fb_fwd_r  <= 1'b1;
			mstep_r   <= 1'b0;
			mfwd_r    <= 1'b1;
		end else begin
			enc_a_r   <= enc_a_nxt;
			enc_b_r   <= enc_b_nxt;
			fb_step_r <= fb_step_nxt;
			fb_fwd_r  <= fb_fwd_nxt;
			mstep_r   <= mstep_nxt;
			mfwd_r    <= mfwd_nxt;
		end
	end

	assign fb_if.step = fb_step_r;
	assign fb_if.fwd  = fb_fwd_r;

	sso_enc_div u_div (
		.clk_sys (clk_sys),
		.rst     (rst),
		.fb      (fb_if.snk),
		.rate    (encoder_divider_rate),
		.swap    (reversed),
		.enc_z   (enc_z_in),
		.a_out   (enc_a_out),
		.b_out   (enc_b_out),
		.z_out   (enc_z_out)
	);

	// ----------------------------------------
	// deviation counter and detection outputs
	// ----------------------------------------
	always_comb begin
		dev_nxt = dev_r;
		if (mstep_r) begin
			dev_nxt = mfwd_r ? dev_nxt + DEV_W'(1) : dev_nxt - DEV_W'(1);
		end
		if (fb_step_r) begin
			dev_nxt = fb_fwd_r ? dev_nxt - DEV_W'(1) : dev_nxt + DEV_W'(1);
		end
		if (deviation_clear) begin
			dev_nxt = '0;
		end
		dev_mag   = dev_r[DEV_W-1] ? DEV_W'(-dev_r) : dev_r;
		inpos_nxt = dev_mag < DEV_W'(in_position_window);
		trq_lim   = motor_torque[SPD_W-1]
			? lesser(rev_external_current_limit, rev_torque_limit)
			: lesser(fwd_external_current_limit, fwd_torque_limit);
		if (setup_word_one[SETUP1_CURRENT_LIMIT_REACHED_OUT_SEL_BIT]) begin
			det_nxt = fwd_ext_limit_in && rev_ext_limit_in
				&& (mag(motor_torque) >= trq_lim);
		end else begin
			det_nxt = mag(motor_speed) >= rotation_detect_threshold;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dev_r   <= '0;
			inpos_r <= 1'b0;
			det_r   <= 1'b0;
		end else begin
			dev_r   <= dev_nxt;
			inpos_r <= inpos_nxt;
			det_r   <= det_nxt;
		end
	end

	// ----------------------------------------
	// alarm sequencing
	// ----------------------------------------
	always_comb begin
		err_any      = fault_valid | cmd_fast;
		err_code     = fault_valid ? fault_code : CODE_CMD_FAST;
		alm_nxt      = alm_r;
		pwr_nxt      = pwr_r;
		pwr_done_nxt = pwr_done_r;
		code_nxt     = code_r;
		if (!pwr_done_r) begin
			pwr_nxt = pwr_r + CNT_W'(1);
			if (pwr_r == CNT_W'(POWERUP_CYC - 1)) begin
				pwr_done_nxt = 1'b1;
			end
		end
		case (alm_r)
			ALM_POWERUP: begin
				if (err_any) begin
					alm_nxt  = ALM_FAULT;
					code_nxt = err_code;
				end else if (pwr_done_nxt) begin
					alm_nxt = ALM_READY;
				end
			end
			ALM_READY: begin
				if (err_any) begin
					alm_nxt  = ALM_FAULT;
					code_nxt = err_code;
				end
			end
			ALM_FAULT: begin
				// the first cause stays latched until reset with the cause gone
				if (alarm_reset && !err_any) begin
					alm_nxt  = pwr_done_nxt ? ALM_READY : ALM_POWERUP;
					code_nxt = CODE_NONE;
				end
			end
			default: begin
				alm_nxt = ALM_POWERUP;
			end
		endcase
		alm_out_nxt = alm_nxt == ALM_READY;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			alm_r      <= ALM_POWERUP;
			pwr_r      <= '0;
			pwr_done_r <= 1'b0;
			alm_out_r  <= 1'b0;
			code_r     <= CODE_NONE;
		end else begin
			alm_r      <= alm_nxt;
			pwr_r      <= pwr_nxt;
			pwr_done_r <= pwr_done_nxt;
			alm_out_r  <= alm_out_nxt;
			code_r     <= code_nxt;
		end
	end

	// ----------------------------------------
	// brake interlock
	// ----------------------------------------
	always_comb begin
		unit_tick = tick_r == CNT_W'(BRAKE_UNIT_CYC - 1);
		tick_nxt  = unit_tick ? '0 : tick_r + CNT_W'(1);
		run_req   = servo_on && alm_out_r;
		stopped   = mag(motor_speed) < brake_timing_b;
		brk_nxt   = brk_r;
		units_nxt = units_r;
		if (unit_tick && units_r != '1) begin
			units_nxt = units_r + BRK_W'(1);
		end
		case (brk_r)
			BRK_HOLD: begin
				if (run_req) begin
					brk_nxt = BRK_RUN;
				end
			end
			BRK_RUN: begin
				if (!run_req) begin
					brk_nxt   = BRK_STOPPING;
					units_nxt = '0;
				end
			end
			BRK_STOPPING: begin
				// a spinning motor is not held forever: timing c caps the wait
				if (run_req) begin
					brk_nxt = BRK_RUN;
				end else if ((stopped && units_r >= brake_timing_a)
					|| units_r >= brake_timing_c) begin
					brk_nxt = BRK_HOLD;
				end
			end
			default: begin
				brk_nxt = BRK_HOLD;
			end
		endcase
		brk_out_nxt = brk_nxt != BRK_HOLD;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			brk_r     <= BRK_HOLD;
			tick_r    <= '0;
			units_r   <= '0;
			brk_out_r <= 1'b0;
		end else begin
			brk_r     <= brk_nxt;
			tick_r    <= tick_nxt;
			units_r   <= units_nxt;
			brk_out_r <= brk_out_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign in_position_out     = inpos_r;
	assign detect_out          = det_r;
	assign alarm_out           = alm_out_r;
	assign alarm_code_bit0     = code_r[0];
	assign alarm_code_bit1     = code_r[1];
	assign alarm_code_bit2     = code_r[2];
	assign brake_interlock_out = brk_out_r;
	assign motor_step_out      = mstep_r;
	assign motor_fwd_out       = mfwd_r;

endmodule : sso_status_outputs

// [sso_pkg.sv]
// shared constants and types for the servo status output block
package sso_pkg;

	// ----------------------------------------
	// clock and widths
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEV_W         = 24;
	localparam int SPD_W         = 16;
	localparam int WIN_W         = 16;
	localparam int DIV_W         = 16;
	localparam int BRK_W         = 16;
	localparam int SETUP_W       = 16;
	localparam int CODE_W        = 3;
	localparam int MODE_W        = 3;
	localparam int GAP_W         = 10;
	localparam int ACC_W         = 13;
	localparam int CNT_W         = 24;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SETUP1_CURRENT_LIMIT_REACHED_OUT_SEL_BIT = 4;

	// ----------------------------------------
	// command pulse timing
	// ----------------------------------------
	localparam int CMD_MAX_RATE_KPPS  = 200;
	localparam int CMD_MIN_PERIOD_NS  = 1000000 / CMD_MAX_RATE_KPPS;
	localparam int CMD_MIN_PERIOD_CYC = (CMD_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(CMD_MIN_PERIOD_CYC - 1);
	localparam logic [GAP_W-1:0] GAP_MAX = '1;

	// ----------------------------------------
	// start-up and brake timing
	// ----------------------------------------
	localparam int POWERUP_TIME_US = 100;
	localparam int POWERUP_CYC     = POWERUP_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int BRAKE_UNIT_US   = 1000;
	localparam int BRAKE_UNIT_CYC  = BRAKE_UNIT_US * 1000 / CLK_PERIOD_NS;

	// ----------------------------------------
	// encoder regeneration
	// ----------------------------------------
	localparam logic [ACC_W-1:0] ENC_LINES = 13'h0800;

	// ----------------------------------------
	// command pulse modes
	// ----------------------------------------
	localparam logic [MODE_W-1:0] MODE_FEED_DIR = 3'h0;
	localparam logic [MODE_W-1:0] MODE_CW_CCW   = 3'h1;
	localparam logic [MODE_W-1:0] MODE_QUAD_X1  = 3'h2;
	localparam logic [MODE_W-1:0] MODE_QUAD_X2  = 3'h3;
	localparam logic [MODE_W-1:0] MODE_QUAD_X4  = 3'h4;

	// ----------------------------------------
	// alarm codes and reset values
	// ----------------------------------------
	localparam logic [CODE_W-1:0] CODE_NONE     = 3'h0;
	localparam logic [CODE_W-1:0] CODE_CMD_FAST = 3'h6;

	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ALM_POWERUP = 2'b00,
		ALM_READY   = 2'b01,
		ALM_FAULT   = 2'b10
	} sso_alm_state_t;

	typedef enum logic [1:0] {
		BRK_HOLD     = 2'b00,
		BRK_RUN      = 2'b01,
		BRK_STOPPING = 2'b10
	} sso_brk_state_t;

endpackage : sso_pkg

// [sso_step_if.sv]
// step and direction carrier between the block's modules
`timescale 1ns/1ps
interface sso_step_if;
	logic step;
	logic fwd;
	modport src (output step, output fwd);
	modport snk (input step, input fwd);
endinterface : sso_step_if

// [sso_cmd_pulse.sv]
// command pulse decoder with rate check
`timescale 1ns/1ps
module sso_cmd_pulse (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	// pins and setup
	input  wire logic                      pin_a,
	input  wire logic                      pin_b,
	input  wire logic [sso_pkg::MODE_W-1:0] mode,
	input  wire logic                      neg_logic,
	// decoded steps
	sso_step_if.src                        step_o,
	output logic                           too_fast
);
	import sso_pkg::*;

	logic             a_r, a_nxt, b_r, b_nxt;
	logic             step_r, step_nxt, fwd_r, fwd_nxt;
	logic             fast_r, fast_nxt;
	logic [GAP_W-1:0] gap_r, gap_nxt;
	logic             rise_a, rise_b, edge_a, edge_b, primary;

	always_comb begin
		// same decode for both polarities, only the pins are inverted
		a_nxt    = pin_a ^ neg_logic;
		b_nxt    = pin_b ^ neg_logic;
		rise_a   = a_nxt & ~a_r;
		rise_b   = b_nxt & ~b_r;
		edge_a   = a_nxt ^ a_r;
		edge_b   = b_nxt ^ b_r;
		step_nxt = 1'b0;
		fwd_nxt  = fwd_r;
		primary  = 1'b0;
		case (mode)
			MODE_FEED_DIR: begin
				step_nxt = rise_a;
				fwd_nxt  = b_nxt;
				primary  = rise_a;
			end
			MODE_CW_CCW: begin
				step_nxt = rise_a | rise_b;
				fwd_nxt  = rise_b;
				primary  = rise_a | rise_b;
			end
			MODE_QUAD_X1: begin
				step_nxt = rise_a;
				fwd_nxt  = ~b_nxt;
				primary  = rise_a;
			end
			MODE_QUAD_X2: begin
				step_nxt = edge_a;
				fwd_nxt  = a_nxt ^ b_nxt;
				primary  = rise_a;
			end
			MODE_QUAD_X4: begin
				step_nxt = edge_a | edge_b;
				fwd_nxt  = edge_a ? (a_nxt ^ b_nxt) : ~(a_nxt ^ b_nxt);
				primary  = rise_a;
			end
			default: begin
				step_nxt = 1'b0;
			end
		endcase
		// pulses closer than the rate limit still count but raise an alarm
		fast_nxt = primary && (gap_r < GAP_MIN);
		if (primary) begin
			gap_nxt = '0;
		end else if (gap_r != GAP_MAX) begin
			gap_nxt = gap_r + GAP_W'(1);
		end else begin
			gap_nxt = gap_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			a_r    <= 1'b0;
			b_r    <= 1'b0;
			step_r <= 1'b0;
			fwd_r  <= 1'b1;
			fast_r <= 1'b0;
			gap_r  <= GAP_MAX;
		end else begin
			a_r    <= a_nxt;
			b_r    <= b_nxt;
			step_r <= step_nxt;
			fwd_r  <= fwd_nxt;
			fast_r <= fast_nxt;
			gap_r  <= gap_nxt;
		end
	end

	assign step_o.step = step_r;
	assign step_o.fwd  = fwd_r;
	assign too_fast    = fast_r;

endmodule : sso_cmd_pulse

// [sso_enc_div.sv]
// divided quadrature regeneration of encoder feedback
`timescale 1ns/1ps
module sso_enc_div (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	// feedback steps and setup
	sso_step_if.snk                        fb,
	input  wire logic [sso_pkg::DIV_W-1:0] rate,
	input  wire logic                      swap,
	input  wire logic                      enc_z,
	// regenerated phases
	output logic                           a_out,
	output logic                           b_out,
	output logic                           z_out
);
	import sso_pkg::*;

	logic [ACC_W-1:0] acc_r, acc_nxt, rate_eff, sum;
	logic [1:0]       cnt_r, cnt_nxt;
	logic             a_r, a_nxt, b_r, b_nxt, z_r, z_nxt;
	logic             pa, pb;

	always_comb begin
		// rates above the line count saturate: at most one edge out per edge in
		rate_eff = (rate > DIV_W'(ENC_LINES)) ? ENC_LINES : rate[ACC_W-1:0];
		sum      = acc_r + rate_eff;
		acc_nxt  = acc_r;
		cnt_nxt  = cnt_r;
		if (fb.step && fb.fwd) begin
			if (sum >= ENC_LINES) begin
				acc_nxt = sum - ENC_LINES;
				cnt_nxt = cnt_r + 2'h1;
			end else begin
				acc_nxt = sum;
			end
		end else if (fb.step) begin
			if (acc_r >= rate_eff) begin
				acc_nxt = acc_r - rate_eff;
			end else begin
				acc_nxt = acc_r + ENC_LINES - rate_eff;
				cnt_nxt = cnt_r - 2'h1;
			end
		end
		pa    = cnt_nxt[1] ^ cnt_nxt[0];
		pb    = cnt_nxt[1];
		a_nxt = swap ? pb : pa;
		b_nxt = swap ? pa : pb;
		z_nxt = enc_z;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			acc_r <= '0;
			cnt_r <= 2'h0;
			a_r   <= 1'b0;
			b_r   <= 1'b0;
			z_r   <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			cnt_r <= cnt_nxt;
			a_r   <= a_nxt;
			b_r   <= b_nxt;
			z_r   <= z_nxt;
		end
	end

	assign a_out = a_r;
	assign b_out = b_r;
	assign z_out = z_r;

endmodule : sso_enc_div

// [sso_status_outputs_asserts.sv]
// port-level assertions for the servo status output block
`timescale 1ns/1ps
module sso_status_outputs_asserts #(
	parameter int POWERUP_CYC = 20
) (
	// clock and reset
	input wire logic	clk_sys,
	input wire logic	rst,
	// command side
	input wire logic	cmd_pin_a,
	input wire logic	cmd_pin_b,
	input wire logic [sso_pkg::MODE_W-1:0]	cmd_mode,
	input wire logic	cmd_neg_logic,
	input wire logic	dir_reverse_n,
	input wire logic	dir_reverse_cfg,
	input wire logic	motor_step_out,
	input wire logic	motor_fwd_out,
	// status side
	input wire logic	deviation_clear,
	input wire logic [sso_pkg::WIN_W-1:0]	in_position_window,
	input wire logic	in_position_out,
	input wire logic [sso_pkg::SETUP_W-1:0]	setup_word_one,
	input wire logic signed [sso_pkg::SPD_W-1:0]	motor_speed,
	input wire logic [sso_pkg::SPD_W-1:0]	rotation_detect_threshold,
	input wire logic	detect_out,
	input wire logic	fault_valid,
	input wire logic [sso_pkg::CODE_W-1:0]	fault_code,
	input wire logic	alarm_out,
	input wire logic	alarm_code_bit0,
	input wire logic	alarm_code_bit1,
	input wire logic	alarm_code_bit2,
	input wire logic	servo_on,
	input wire logic	brake_interlock_out,
	input wire logic	enc_z_in,
	input wire logic	enc_z_out
);
	import sso_pkg::*;
	logic [15:0]	up_r;
	logic [15:0]	up_nxt;
	logic [2:0]	code;
	// ----------------------------------------
	// cycles since release, saturating
	// ----------------------------------------
	always_comb begin
		up_nxt = (up_r == 16'hffff) ? up_r : up_r + 16'h1;
	end
	always_ff @(posedge clk_sys) begin
		up_r <= rst ? 16'h0 : up_nxt;
	end
	assign code = {alarm_code_bit2, alarm_code_bit1, alarm_code_bit0};
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_feed_rise;
		up_r > 16'h3 && cmd_mode == MODE_FEED_DIR && $rose(cmd_pin_a ^ cmd_neg_logic);
	endsequence
	sequence s_step_once;
		##2 motor_step_out ##1 !motor_step_out;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_step_pulse: assert property (s_feed_rise |-> s_step_once)
		else $error("feed step pulse missing");
	a_step_dir: assert property (s_feed_rise |-> ##2
		motor_fwd_out == $past(cmd_pin_b ^ cmd_neg_logic ^ (!dir_reverse_n | dir_reverse_cfg), 2))
		else $error("step direction wrong");
	a_inpos_clear: assert property ((deviation_clear && up_r > 16'h3)[*3] |->
		in_position_out == ($past(in_position_window) != 16'h0))
		else $error("in-position wrong at zero deviation");
	a_rot_detect: assert property (up_r > 16'h3 && $past(!setup_word_one[4] && !motor_speed[15])
		|-> detect_out == $past(motor_speed >= rotation_detect_threshold))
		else $error("rotation detect wrong");
	a_alarm_fault: assert property (fault_valid && alarm_out |=>
		!alarm_out && code == $past(fault_code))
		else $error("alarm did not latch fault");
	a_code_idle: assert property (alarm_out |-> code == CODE_NONE)
		else $error("code shown without alarm");
	a_powerup_off: assert property (up_r < POWERUP_CYC |-> !alarm_out)
		else $error("alarm on during start-up");
	a_brake_release: assert property ($rose(brake_interlock_out) |-> $past(servo_on && alarm_out))
		else $error("brake released without run");
	a_enc_z: assert property (up_r > 16'h3 |-> enc_z_out == $past(enc_z_in))
		else $error("z phase not passed on");
endmodule : sso_status_outputs_asserts
bind sso_status_outputs sso_status_outputs_asserts #(.POWERUP_CYC(POWERUP_CYC)) chk_u (.*);

// [sso_ctrl_model.sv]
// external position controller model driving the command pins
`timescale 1ns/1ps
module sso_ctrl_model (
	// clock
	input wire logic	clk_sys,
	// setup shared with the drive
	input wire logic [sso_pkg::MODE_W-1:0]	mode,
	input wire logic	neg,
	// command pins
	output logic	cmd_pin_a,
	output logic	cmd_pin_b
);
	import sso_pkg::*;
	logic [1:0]	ab_r;
	// negative logic only inverts levels, timing unchanged
	assign cmd_pin_a = ab_r[1] ^ neg;
	assign cmd_pin_b = ab_r[0] ^ neg;
	initial begin
		ab_r = 2'b00;
	end
	// one unit in four quarters of q cycles; q under 125 breaks the rate on purpose
	task automatic send(input logic fwd, input int q);
		for (int i = 0; i < 4; i++) begin
			case (mode)
				MODE_FEED_DIR: ab_r = {1'(i == 1 || i == 2), fwd};
				MODE_CW_CCW: ab_r = (i == 1 || i == 2) ? (fwd ? 2'b01 : 2'b10) : 2'b00;
				default: ab_r = 2'((fwd ? 8'h1e : 8'h2d) >> (2 * i));
			endcase
			repeat (q) @(posedge clk_sys);
			#1;
		end
	endtask : send
endmodule : sso_ctrl_model

// [sso_status_outputs_test.sv]
// self-checking bench for the servo status output block
`timescale 1ns/1ps
`define CHK(g, x) begin \
	samples_checked++; \
	if ((g) !== (x)) begin \
		fails++; \
		$display("[FAIL] %0t got %h exp %h", $time, (g), (x)); \
	end \
end
module sso_status_outputs_test;
	import sso_pkg::*;
	logic clk_sys, rst, cmd_pin_a, cmd_pin_b, cmd_neg_logic, deviation_clear, f;
	logic enc_a_in, enc_b_in, enc_z_in, dir_reverse_n, dir_reverse_cfg, servo_on;
	logic fwd_ext_limit_in, rev_ext_limit_in, fault_valid, alarm_reset;
	logic [MODE_W-1:0] cmd_mode;
	logic [WIN_W-1:0] in_position_window;
	logic [SETUP_W-1:0] setup_word_one;
	logic [SPD_W-1:0] rotation_detect_threshold, fwd_external_current_limit;
	logic [SPD_W-1:0] rev_external_current_limit, fwd_torque_limit, rev_torque_limit;
	logic [DIV_W-1:0] encoder_divider_rate;
	logic [BRK_W-1:0] brake_timing_a, brake_timing_b, brake_timing_c;
	logic signed [SPD_W-1:0] motor_speed, motor_torque;
	logic [CODE_W-1:0] fault_code, code_w;
	logic in_position_out, detect_out, alarm_out, alarm_code_bit0, alarm_code_bit1;
	logic alarm_code_bit2, brake_interlock_out, enc_a_out, enc_b_out, enc_z_out;
	logic motor_step_out, motor_fwd_out;
	logic [1:0] ab_prev;
	logic [1:0] chg_q[$];
	int fails, samples_checked, nsteps, n0, s, t, e, b, lim;
	int exp_per[5] = '{1, 1, 1, 2, 4};
	assign code_w = {alarm_code_bit2, alarm_code_bit1, alarm_code_bit0};
	sso_status_outputs #(.POWERUP_CYC(20), .BRAKE_UNIT_CYC(10)) dut_u (.*);
	sso_ctrl_model ctrl_u (.clk_sys(clk_sys), .mode(cmd_mode), .neg(cmd_neg_logic),
		.cmd_pin_a(cmd_pin_a), .cmd_pin_b(cmd_pin_b));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// reference model: step count and phase changes
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (motor_step_out === 1'b1)
			nsteps++;
		if ({enc_a_out, enc_b_out} !== ab_prev)
			chg_q.push_back({enc_a_out, enc_b_out});
		ab_prev = {enc_a_out, enc_b_out};
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : hold
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task automatic clear_alarm;
		int n;
		n = 0;
		alarm_reset = 1'b1;
		hold(1);
		alarm_reset = 1'b0;
		while (alarm_out !== 1'b1) begin
			hold(1);
			n++;
			if (n > 40) begin
				fails++;
				summarize();
			end
		end
	endtask : clear_alarm
	initial begin
		hold(90000);
		fails++;
		summarize();
	end
	initial begin
		{rst, dir_reverse_n, ab_prev} = 4'hc;
		{cmd_mode, cmd_neg_logic, deviation_clear, dir_reverse_cfg, servo_on} = '0;
		{enc_a_in, enc_b_in, enc_z_in, fwd_ext_limit_in, rev_ext_limit_in} = '0;
		{fault_valid, fault_code, alarm_reset, in_position_window, setup_word_one} = '0;
		{rotation_detect_threshold, fwd_external_current_limit, fwd_torque_limit} = '0;
		{rev_external_current_limit, rev_torque_limit, motor_speed, motor_torque} = '0;
		{brake_timing_a, brake_timing_b, brake_timing_c} = {16'h2, 16'ha, 16'h32};
		encoder_divider_rate = 16'h0800;
		{fails, samples_checked, nsteps} = '0;
		void'($urandom(32'hb8a6));
		hold(2);
		rst = 1'b0;
		hold(19);
		`CHK(alarm_out, 1'b0)
		hold(1);
		`CHK(alarm_out, 1'b1)
		$display("done start-up");
		for (int m = 0; m < 5; m++) begin
			cmd_mode = 3'(m);
			{cmd_neg_logic, dir_reverse_n, dir_reverse_cfg, f} = 4'($urandom);
			hold(200);
			n0 = nsteps;
			repeat (2) ctrl_u.send(f, 130);
			hold(4);
			`CHK(nsteps - n0, exp_per[m] * 2)
			`CHK(motor_fwd_out, f ^ (!dir_reverse_n | dir_reverse_cfg))
		end
		`CHK(alarm_out, 1'b1)
		{cmd_mode, cmd_neg_logic, dir_reverse_n, dir_reverse_cfg} = 6'h4;
		deviation_clear = 1'b1;
		for (int w = 0; w < 5; w++) begin
			if (w == 2) begin
				deviation_clear = 1'b0;
				hold(200);
				repeat (3) ctrl_u.send(1'b1, 130);
			end
			in_position_window = 16'(w + (w > 1));
			hold(3);
			`CHK(in_position_out, 1'(w == 1 || w > 2))
		end
		hold(200);
		ctrl_u.send(1'b1, 130);
		ctrl_u.send(1'b1, 20);
		`CHK(alarm_out, 1'b0)
		`CHK(code_w, CODE_CMD_FAST)
		clear_alarm();
		for (int c = 1; c < 8; c++) begin
			{fault_code, fault_valid} = {3'(c), 1'b1};
			hold(2);
			fault_code = ~3'(c);
			hold(2);
			`CHK(alarm_out, 1'b0)
			`CHK(code_w, 3'(c))
			fault_valid = 1'b0;
			clear_alarm();
		end
		$display("done command and alarm");
		for (int i = 0; i < 8; i++) begin
			setup_word_one = 16'($urandom);
			{s, t, lim} = {$urandom_range(0, 999), $urandom_range(0, 999), $urandom_range(0, 999)};
			e = (i == 0) ? s : $urandom_range(0, 999);
			b = (i == 1) ? t : $urandom_range(0, 999);
			{motor_speed, motor_torque, rotation_detect_threshold} = {16'(s), 16'(t), 16'(e)};
			{fwd_external_current_limit, fwd_torque_limit} = {16'(lim), 16'(b)};
			{rev_external_current_limit, rev_torque_limit} = 32'($urandom);
			{fwd_ext_limit_in, rev_ext_limit_in} = 2'b11;
			hold(2);
			if (setup_word_one[4])
				`CHK(detect_out, 1'(t >= ((lim < b) ? lim : b)))
			else
				`CHK(detect_out, 1'(s >= e))
		end
		for (int k = 0; k < 3; k++) begin
			dir_reverse_n = (k != 1);
			encoder_divider_rate = (k == 2) ? 16'h0400 : 16'h0800;
			hold(2);
			chg_q.delete();
			for (int i = 0; i < 8; i++) begin
				{enc_a_in, enc_b_in, enc_z_in} = {2'(8'h1e >> (2 * (i % 4))), 1'(i == 3)};
				hold(3);
			end
			hold(4);
			`CHK(chg_q.size(), (k == 2) ? 4 : 8)
			`CHK(chg_q[0], (k == 1) ? 2'b01 : 2'b10)
		end
		{motor_speed, servo_on} = {16'h0, 1'b1};
		hold(2);
		`CHK(brake_interlock_out, 1'b1)
		servo_on = 1'b0;
		hold(12);
		`CHK(brake_interlock_out, 1'b1)
		hold(12);
		`CHK(brake_interlock_out, 1'b0)
		$display("done detect, encoder and brake");
		summarize();
	end
endmodule : sso_status_outputs_test
